// >>> range_extraction.sv
`include "range_regs.svh"
`default_nettype none

// Notes on behaviour
// R1: each channel's result is coarse and fine combined, 24 bits, complemented.
// R2: start pulse arrives during transmit epoch bit and arms the coarse interval.
// R3: coarse interval ends on the next receive epoch marker of the channel.
// R4: coarse interval counts whole code-clock cycles between the two markers.
// R5: fine counter is seven bits, 128 counts for a full phase turn.
// R6: fine count starts on transmit beat crossing, stops on receive beat crossing.
// R7: coarse clock is the double-rate clock halved; the halving bit is the overlap.
// R8: fine count falls into six segments with bounds 8, 16, 32, 48, 56, 127.
// R9: first segment with overlap one misses a count; last with zero adds one.
// R10: second segment with one and fifth with zero are impossible, no special case.
// R11: coarse counter advances on falling edges of the coarse clock.
// R12: coarse counter is preset to all ones, one count below zero.
// R13: add two for missed, one for correct, none for extra count.
// R14: start and stop on first double-rate falling edge after epoch bit falls.
// R15: receive marker arms fine interval; it starts on next reference beat fall.
// R16: fine interval ends on first receive beat falling edge after it began.
// R17: correction begins 20 us after fine end and takes at most 30 us.
// R18: fine counter counts the transmit code clock.
// R19: four identical channels share the reference beat logic.
// R20: coarse register is 17 bits; its complement goes to readout.
// R21: fine counter preset to all ones; start count rolls it to zero.
// R22: each correction count is a 100 kHz pulse; add-two gives two pulses.
// R23: start pulse presets coarse and fine registers to all ones and arms every channel.
// R24: corrected result holds stable until the next start pulse.
// R25: correction command is decoded only after the fine interval ends.
module range_extraction #(
    parameter int unsigned SETTLE_CYC = `RNG_SETTLE_CYC
) (
    input  wire logic                         clock,
    input  wire logic                         rstn,
    input  wire logic                         start_measure,
    input  wire logic                         tx_epoch_bit,
    input  wire logic                         tx_double_rate_clock,
    input  wire logic                         tx_code_clock,
    input  wire logic                         tx_beat,
    input  wire logic [`RNG_CHANNELS-1:0]     rx_epoch_bit,
    input  wire logic [`RNG_CHANNELS-1:0]     rx_double_rate_clock,
    input  wire logic [`RNG_CHANNELS-1:0]     rx_beat,
    output var  logic [`RNG_CHANNELS-1:0][`RNG_RESULT_W-1:0] range_result,
    output var  logic [`RNG_CHANNELS-1:0]     result_valid,
    output var  logic [`RNG_CHANNELS-1:0]     busy
);

    // place a fine count into its phase segment
    function automatic range_pkg::segment_e classify(input logic [6:0] value);
        range_pkg::segment_e seg;
        seg = range_pkg::SEG_LAST;
        if (value <= `RNG_SEG1_HI) begin
            seg = range_pkg::SEG_FIRST;                // [R8]
        end else if (value <= `RNG_SEG2_HI) begin
            seg = range_pkg::SEG_SECOND;
        end else if (value <= `RNG_SEG3_HI) begin
            seg = range_pkg::SEG_THIRD;
        end else if (value <= `RNG_SEG4_HI) begin
            seg = range_pkg::SEG_FOURTH;
        end else if (value <= `RNG_SEG5_HI) begin
            seg = range_pkg::SEG_FIFTH;
        end
        return seg;
    endfunction

    // number of counts to insert for a segment and overlap bit
    function automatic logic [1:0] add_count(input range_pkg::segment_e seg,
                                             input logic half_bit);
        logic [1:0] adds;
        adds = 2'h1;                                   // correct, and both impossible cases [R10]
        if (seg == range_pkg::SEG_FIRST && half_bit) begin
            adds = 2'h2;                               // missed a count [R9] [R13]
        end else if (seg == range_pkg::SEG_LAST && !half_bit) begin
            adds = 2'h0;                               // one count too many [R9] [R13]
        end
        return adds;
    endfunction

    ref_if evt ();

    // shared transmit edge pulses and correction pulse timing
    ref_shared u_shared (                              // [R19]
        .clock                (clock),
        .rstn                 (rstn),
        .tx_epoch_bit         (tx_epoch_bit),
        .tx_double_rate_clock (tx_double_rate_clock),
        .tx_code_clock        (tx_code_clock),
        .tx_beat              (tx_beat),
        .evt                  (evt.src)
    );

    // four identical channels
    for (genvar ch = 0; ch < `RNG_CHANNELS; ch++) begin : g_chan
        range_pkg::chan_s ch_ff;
        range_pkg::chan_s nxt_ch;
        logic             rx_epoch_fall;
        logic             rx_dr_fall;
        logic             rx_beat_fall;

        // receive-side edges seen against the previous sample
        assign rx_epoch_fall = ch_ff.rx_epoch_d & ~rx_epoch_bit[ch];
        assign rx_dr_fall    = ch_ff.rx_dr_d & ~rx_double_rate_clock[ch];
        assign rx_beat_fall  = ch_ff.rx_beat_d & ~rx_beat[ch];

        // measurement sequence of one channel
        always_comb begin
            nxt_ch = ch_ff;
            nxt_ch.rx_epoch_d = rx_epoch_bit[ch];
            nxt_ch.rx_dr_d    = rx_double_rate_clock[ch];
            nxt_ch.rx_beat_d  = rx_beat[ch];
            case (ch_ff.state)
                range_pkg::ST_IDLE: begin
                    nxt_ch.state = range_pkg::ST_IDLE;
                end
                range_pkg::ST_ARM: begin
                    // wait for the transmit epoch bit to drop
                    if (evt.tx_epoch_fall) begin
                        nxt_ch.state = range_pkg::ST_START_WAIT;   // [R2]
                    end
                end
                range_pkg::ST_START_WAIT: begin
                    // interval opens on the next double-rate falling edge
                    if (evt.tx_dr_fall) begin
                        nxt_ch.state = range_pkg::ST_COARSE;       // [R14]
                    end
                end
                range_pkg::ST_COARSE, range_pkg::ST_STOP_WAIT: begin
                    if (ch_ff.state == range_pkg::ST_STOP_WAIT && rx_dr_fall) begin
                        // stop wins over a coincident count edge
                        nxt_ch.state = range_pkg::ST_FINE_ARM;     // [R3] [R14] [R15]
                    end else begin
                        if (ch_ff.state == range_pkg::ST_COARSE && rx_epoch_fall) begin
                            nxt_ch.state = range_pkg::ST_STOP_WAIT; // [R3]
                        end
                        if (evt.tx_dr_fall) begin
                            // halving bit toggles; its fall clocks the coarse counter
                            nxt_ch.half_cycle_bit = ~ch_ff.half_cycle_bit;  // [R7]
                            if (ch_ff.half_cycle_bit) begin
                                nxt_ch.coarse = ch_ff.coarse + 17'h00001;  // [R4] [R11]
                            end
                        end
                    end
                end
                range_pkg::ST_FINE_ARM: begin
                    // opening edge gives the extra count that rolls all ones to zero
                    if (evt.tx_beat_fall) begin
                        nxt_ch.fine  = ch_ff.fine + 7'h01;         // [R21]
                        nxt_ch.state = range_pkg::ST_FINE_RUN;     // [R6] [R15]
                    end
                end
                range_pkg::ST_FINE_RUN: begin
                    if (rx_beat_fall) begin
                        nxt_ch.state = range_pkg::ST_SETTLE;       // [R6] [R16]
                        nxt_ch.timer = '0;
                    end else if (evt.tx_code_rise) begin
                        nxt_ch.fine = ch_ff.fine + 7'h01;          // [R5] [R18]
                    end
                end
                range_pkg::ST_SETTLE: begin
                    // hold off the correction for the settling time
                    if (ch_ff.timer == `RNG_TIMER_W'(SETTLE_CYC - 1)) begin
                        nxt_ch.adds  = add_count(classify(ch_ff.fine),
                                                 ch_ff.half_cycle_bit);  // [R25]
                        nxt_ch.state = range_pkg::ST_CORRECT;      // [R17]
                    end else begin
                        nxt_ch.timer = ch_ff.timer + `RNG_TIMER_W'(1);
                    end
                end
                range_pkg::ST_CORRECT: begin
                    if (ch_ff.adds == 2'h0) begin
                        // correction complete: publish complemented result
                        nxt_ch.result = ~{ch_ff.coarse, ch_ff.fine};  // [R1] [R20]
                        nxt_ch.valid  = 1'b1;
                        nxt_ch.state  = range_pkg::ST_IDLE;        // [R24]
                    end else if (evt.insert_tick) begin
                        // one inserted coarse clock pulse per 100 kHz tick
                        nxt_ch.coarse = ch_ff.coarse + 17'h00001;  // [R13] [R22]
                        nxt_ch.adds   = ch_ff.adds - 2'h1;         // [R17]
                    end
                end
                default: begin
                    nxt_ch.state = range_pkg::ST_IDLE;
                end
            endcase
            // start pulse presets registers and arms the channel from any state
            if (start_measure) begin
                nxt_ch.state          = range_pkg::ST_ARM;         // [R2] [R23]
                nxt_ch.coarse         = `RNG_COARSE_PRESET;        // [R12] [R23]
                nxt_ch.fine           = `RNG_FINE_PRESET;          // [R21] [R23]
                nxt_ch.half_cycle_bit = 1'b0;
                nxt_ch.adds           = 2'h0;
                nxt_ch.timer          = '0;
                nxt_ch.result         = '0;                        // [R24]
                nxt_ch.valid          = 1'b0;
            end
            // busy follows the next state so the output leaves a flop
            nxt_ch.busy = (nxt_ch.state != range_pkg::ST_IDLE);
        end

        // channel state register
        always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
                ch_ff <= '{state: range_pkg::ST_IDLE, coarse: `RNG_COARSE_PRESET,
                           fine: `RNG_FINE_PRESET, default: '0};
            end else begin
                ch_ff <= nxt_ch;
            end
        end

        // outputs come straight from the channel register
        assign range_result[ch] = ch_ff.result;
        assign result_valid[ch] = ch_ff.valid;
        assign busy[ch]         = ch_ff.busy;
    end

endmodule

`default_nettype wire

// >>> range_regs.svh
`ifndef RANGE_REGS_SVH
`define RANGE_REGS_SVH

// channel count and word widths
`define RNG_CHANNELS        4
`define RNG_COARSE_W        17
`define RNG_FINE_W          7
`define RNG_RESULT_W        24

// preset values loaded by the start-measurement pulse
`define RNG_COARSE_PRESET   17'h1ffff
`define RNG_FINE_PRESET     7'h7f

// upper bounds of phase segments one to five; segment six runs to 7'h7f
`define RNG_SEG1_HI         7'h08
`define RNG_SEG2_HI         7'h10
`define RNG_SEG3_HI         7'h20
`define RNG_SEG4_HI         7'h30
`define RNG_SEG5_HI         7'h38

// timing: system clock rate and correction timing in their own units
`define RNG_CLK_MHZ         250
`define RNG_SETTLE_US       20
`define RNG_CORR_MAX_US     30
`define RNG_INSERT_KHZ      100

// derived cycle counts
`define RNG_SETTLE_CYC      (`RNG_SETTLE_US * `RNG_CLK_MHZ)
`define RNG_INSERT_CYC      ((`RNG_CLK_MHZ * 1000) / `RNG_INSERT_KHZ)
`define RNG_INSERT_W        12
`define RNG_TIMER_W         16

`endif

// >>> range_pkg.sv
`default_nettype none

package range_pkg;

    // per-channel measurement sequence, one-hot
    typedef enum logic [8:0] {
        ST_IDLE       = 9'h001,
        ST_ARM        = 9'h002,
        ST_START_WAIT = 9'h004,
        ST_COARSE     = 9'h008,
        ST_STOP_WAIT  = 9'h010,
        ST_FINE_ARM   = 9'h020,
        ST_FINE_RUN   = 9'h040,
        ST_SETTLE     = 9'h080,
        ST_CORRECT    = 9'h100
    } phase_e;

    // phase segment of the fine count, one-hot
    typedef enum logic [5:0] {
        SEG_FIRST  = 6'h01,
        SEG_SECOND = 6'h02,
        SEG_THIRD  = 6'h04,
        SEG_FOURTH = 6'h08,
        SEG_FIFTH  = 6'h10,
        SEG_LAST   = 6'h20
    } segment_e;

    // state of one measurement channel
    typedef struct packed {
        phase_e      state;
        logic [16:0] coarse;
        logic [6:0]  fine;
        logic        half_cycle_bit;
        logic [1:0]  adds;
        logic [15:0] timer;
        logic        rx_epoch_d;
        logic        rx_dr_d;
        logic        rx_beat_d;
        logic [23:0] result;
        logic        valid;
        logic        busy;
    } chan_s;

    // state of the shared reference logic
    typedef struct packed {
        logic        tx_epoch_d;
        logic        tx_dr_d;
        logic        tx_code_d;
        logic        tx_beat_d;
        logic        tx_epoch_fall;
        logic        tx_dr_fall;
        logic        tx_code_rise;
        logic        tx_beat_fall;
        logic        insert_tick;
        logic [11:0] insert_div;
    } shared_s;

endpackage

`default_nettype wire

// >>> ref_if.sv
`default_nettype none

// shared transmit-side events and the correction insert tick handed to every channel
interface ref_if;
    logic tx_epoch_fall;
    logic tx_dr_fall;
    logic tx_code_rise;
    logic tx_beat_fall;
    logic insert_tick;

    modport src (
        output tx_epoch_fall,
        output tx_dr_fall,
        output tx_code_rise,
        output tx_beat_fall,
        output insert_tick
    );

    modport dst (
        input  tx_epoch_fall,
        input  tx_dr_fall,
        input  tx_code_rise,
        input  tx_beat_fall,
        input  insert_tick
    );
endinterface

`default_nettype wire

// >>> ref_shared.sv
`include "range_regs.svh"
`default_nettype none

module ref_shared (
    input  wire logic clock,
    input  wire logic rstn,
    input  wire logic tx_epoch_bit,
    input  wire logic tx_double_rate_clock,
    input  wire logic tx_code_clock,
    input  wire logic tx_beat,
    ref_if.src        evt
);

    range_pkg::shared_s sh_ff;
    range_pkg::shared_s nxt_sh;

    // edge pulses of transmit signals and the correction pulse divider
    always_comb begin
        nxt_sh = sh_ff;
        nxt_sh.tx_epoch_d    = tx_epoch_bit;
        nxt_sh.tx_dr_d       = tx_double_rate_clock;
        nxt_sh.tx_code_d     = tx_code_clock;
        nxt_sh.tx_beat_d     = tx_beat;
        nxt_sh.tx_epoch_fall = sh_ff.tx_epoch_d & ~tx_epoch_bit;
        nxt_sh.tx_dr_fall    = sh_ff.tx_dr_d & ~tx_double_rate_clock;
        nxt_sh.tx_code_rise  = ~sh_ff.tx_code_d & tx_code_clock;
        nxt_sh.tx_beat_fall  = sh_ff.tx_beat_d & ~tx_beat;
        nxt_sh.insert_tick   = 1'b0;
        if (sh_ff.insert_div == `RNG_INSERT_W'(`RNG_INSERT_CYC - 1)) begin
            nxt_sh.insert_div  = '0;
            nxt_sh.insert_tick = 1'b1;                 // [R22]
        end else begin
            nxt_sh.insert_div = sh_ff.insert_div + `RNG_INSERT_W'(1);
        end
    end

    // state register
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sh_ff <= '0;
        end else begin
            sh_ff <= nxt_sh;
        end
    end

    // events leave straight from flip-flops
    assign evt.tx_epoch_fall = sh_ff.tx_epoch_fall;
    assign evt.tx_dr_fall    = sh_ff.tx_dr_fall;
    assign evt.tx_code_rise  = sh_ff.tx_code_rise;
    assign evt.tx_beat_fall  = sh_ff.tx_beat_fall;
    assign evt.insert_tick   = sh_ff.insert_tick;

endmodule

`default_nettype wire

// >>> range_extraction_props.sv
`include "range_regs.svh"
`default_nettype none

module range_extraction_props #(
    parameter int unsigned SETTLE_CYC = `RNG_SETTLE_CYC
) (
    input  wire logic                                        clock,
    input  wire logic                                        rstn,
    input  wire logic                                        start_measure,
    input  wire logic [`RNG_CHANNELS-1:0]                    rx_beat,
    input  wire logic [`RNG_CHANNELS-1:0][`RNG_RESULT_W-1:0] range_result,
    input  wire logic [`RNG_CHANNELS-1:0]                    result_valid,
    input  wire logic [`RNG_CHANNELS-1:0]                    busy
);
    localparam int CORR_BOUND = SETTLE_CYC + `RNG_CORR_MAX_US * `RNG_CLK_MHZ;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);

    AST_START_ARMS_ALL: assert property (start_measure |=> busy == 4'hf)
        else $error("start did not arm every channel");
    AST_START_CLEARS: assert property (
        start_measure |=> result_valid == 4'h0 && range_result == '0)
        else $error("start did not clear results");
    COV_ALL_DONE: cover property (result_valid == 4'hf);
    COV_ABORT: cover property (start_measure && busy != 4'h0);
    COV_CH0_DONE: cover property ($rose(result_valid[0]));

    for (genvar i = 0; i < 4; i++) begin : g_ch
        logic [15:0] since_ff;
        logic        beat_ff;
        // cycles since the latest receive beat fall of a running channel
        always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
                since_ff <= 16'h0000;
                beat_ff  <= 1'b1;
            end else begin
                beat_ff <= rx_beat[i];
                if (busy[i] && beat_ff && !rx_beat[i])
                    since_ff <= 16'h0001;
                else if (busy[i] && since_ff != 16'h0000)
                    since_ff <= since_ff + 16'h0001;
                else
                    since_ff <= 16'h0000;
            end
        end
        AST_RESULT_HOLDS: assert property (
            result_valid[i] && !start_measure |=> result_valid[i] && $stable(range_result[i]))
            else $error("published result changed");
        AST_PUBLISH_ENDS_RUN: assert property (
            $rose(result_valid[i]) |-> !busy[i] && $past(busy[i]))
            else $error("result published outside a run");
        AST_RUN_ENDS_PUBLISHED: assert property ($fell(busy[i]) |-> result_valid[i])
            else $error("run ended without a result");
        AST_NO_RESULT_WHILE_BUSY: assert property (
            busy[i] |-> !result_valid[i] && range_result[i] == '0)
            else $error("result seen during a run");
        AST_SETTLE_WAIT: assert property ($rose(result_valid[i]) |-> since_ff >= SETTLE_CYC)
            else $error("correction began before the settle time");
        AST_CORRECT_BOUNDED: assert property (since_ff < CORR_BOUND)
            else $error("correction took too long");
    end
endmodule

bind range_extraction range_extraction_props #(.SETTLE_CYC(SETTLE_CYC)) props_u (
    .clock(clock),
    .rstn(rstn),
    .start_measure(start_measure),
    .rx_beat(rx_beat),
    .range_result(range_result),
    .result_valid(result_valid),
    .busy(busy)
);

`default_nettype wire

// >>> far_side_model.sv
`default_nettype none

module far_side_model (
    input  wire logic            clock,
    input  wire logic            go,
    input  wire logic [3:0][3:0] stop_per,
    input  wire logic [3:0][6:0] fine_cnt,
    output var  logic            idle,
    output var  logic            tx_epoch_bit,
    output var  logic            tx_double_rate_clock,
    output var  logic            tx_code_clock,
    output var  logic            tx_beat,
    output var  logic [3:0]      rx_epoch_bit,
    output var  logic [3:0]      rx_double_rate_clock,
    output var  logic [3:0]      rx_beat
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_ff = 4'h0;

    // free-running code clocks: double rate every 8 cycles, code clock every 16
    always @(posedge clock)
        cnt_ff <= cnt_ff + 4'h1;
    assign tx_double_rate_clock = cnt_ff[2];
    assign tx_code_clock = cnt_ff[3];
    assign rx_double_rate_clock = {4{cnt_ff[2]}};

    // one frame per go: epochs and beats placed midway between clock edges
    initial begin
        idle = 1'b1;
        tx_epoch_bit = 1'b1;
        tx_beat = 1'b1;
        rx_epoch_bit = 4'hf;
        rx_beat = 4'hf;
        forever begin
            @(posedge clock);
            if (go) begin
                idle <= 1'b0;
                while (cnt_ff != 4'h3)
                    @(posedge clock);
                tx_epoch_bit <= 1'b0;
                for (int t = 1; t <= 2200; t++) begin
                    @(posedge clock);
                    if (t == 124)
                        tx_beat <= 1'b0;
                    for (int i = 0; i < 4; i++) begin
                        if (t == 8 * int'(stop_per[i]))
                            rx_epoch_bit[i] <= 1'b0;
                        if (t == 128 + 16 * int'(fine_cnt[i]))
                            rx_beat[i] <= 1'b0;
                    end
                end
                tx_epoch_bit <= 1'b1;
                tx_beat <= 1'b1;
                rx_epoch_bit <= 4'hf;
                rx_beat <= 4'hf;
                idle <= 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// >>> range_extraction_test.sv
`include "range_regs.svh"
`default_nettype none

module range_extraction_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clock = 1'b0;
    logic                  rstn = 1'b0;
    logic                  start_measure = 1'b0;
    logic                  go = 1'b0;
    logic [3:0][3:0]       stop_per = '0;
    logic [3:0][6:0]       fine_cnt = '0;
    logic                  idle;
    logic                  tx_epoch_bit;
    logic                  tx_dr;
    logic                  tx_code;
    logic                  tx_beat;
    logic [3:0]            rx_epoch_bit;
    logic [3:0]            rx_dr;
    logic [3:0]            rx_beat;
    logic [3:0][23:0]      range_result;
    logic [3:0]            result_valid;
    logic [3:0]            busy;
    int                    fails = 0;
    int                    compares = 0;

    always #2 clock = ~clock;

    range_extraction #(.SETTLE_CYC(20)) dut_u (
        .clock(clock),
        .rstn(rstn),
        .start_measure(start_measure),
        .tx_epoch_bit(tx_epoch_bit),
        .tx_double_rate_clock(tx_dr),
        .tx_code_clock(tx_code),
        .tx_beat(tx_beat),
        .rx_epoch_bit(rx_epoch_bit),
        .rx_double_rate_clock(rx_dr),
        .rx_beat(rx_beat),
        .range_result(range_result),
        .result_valid(result_valid),
        .busy(busy)
    );

    far_side_model far_u (
        .clock(clock),
        .go(go),
        .stop_per(stop_per),
        .fine_cnt(fine_cnt),
        .idle(idle),
        .tx_epoch_bit(tx_epoch_bit),
        .tx_double_rate_clock(tx_dr),
        .tx_code_clock(tx_code),
        .tx_beat(tx_beat),
        .rx_epoch_bit(rx_epoch_bit),
        .rx_double_rate_clock(rx_dr),
        .rx_beat(rx_beat)
    );

    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // m double-rate periods between markers, f fine counts
    function automatic logic [23:0] expect_result(input int m, input int f);
        int k;
        int adds;
        logic [16:0] coarse;
        k = m - 1;
        adds = (f <= 8 && k % 2 == 1) ? 2 : ((f >= 57 && k % 2 == 0) ? 0 : 1);
        coarse = 17'(k / 2 - 1 + adds);
        return ~{coarse, 7'(f)};
    endfunction

    task automatic pulse_start();
        @(posedge clock);
        start_measure <= 1'b1;
        @(posedge clock);
        start_measure <= 1'b0;
        #1;
        check("busy", 24'(busy), 24'h00000f);
        check("cleared", 24'(result_valid) | range_result[2], 24'h000000);
    endtask

    task automatic pulse_go();
        @(posedge clock);
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
    endtask

    task automatic measure(input logic [3:0][3:0] m, input logic [3:0][6:0] f, input bit abort);
        logic [3:0][23:0] held;
        int n;
        stop_per <= m;
        fine_cnt <= f;
        pulse_start();
        pulse_go();
        if (abort) begin
            repeat (60) @(posedge clock);
            pulse_start();
            while (!idle) @(posedge clock);
            pulse_go();
        end
        n = 0;
        while (result_valid !== 4'hf && n < 12000) begin
            @(posedge clock);
            n++;
        end
        check("valid", 24'(result_valid), 24'h00000f);
        for (int i = 0; i < 4; i++)
            check("range", range_result[i], expect_result(m[i], f[i]));
        held = range_result;
        repeat (300) @(posedge clock);
        check("held", 24'(range_result === held && result_valid === 4'hf), 24'h1);
        while (!idle) @(posedge clock);
    endtask

    // segment bounds 8/9 with half bit set, 56/57 with it clear
    task automatic test_segment_bounds();
        measure({4'h5, 4'h5, 4'h4, 4'h4}, {7'h39, 7'h38, 7'h09, 7'h08}, 1'b0);
    endtask

    // empty and full fine counts, shortest and longest coarse spans
    task automatic test_extremes();
        measure({4'hc, 4'h6, 4'h3, 4'h2}, {7'h1f, 7'h2f, 7'h7f, 7'h00}, 1'b0);
    endtask

    // a second start in mid-run discards the first frame
    task automatic test_abort();
        measure({4'h7, 4'h8, 4'h9, 4'ha}, {7'h10, 7'h39, 7'h38, 7'h20}, 1'b1);
    endtask

    task automatic conclude();
        if (fails == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // reset, then the scenarios
    initial begin
        @(posedge clock);
        #1;
        check("reset", 24'(result_valid) | 24'(busy) | range_result[0], 24'h000000);
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        test_segment_bounds();
        test_extremes();
        test_abort();
        conclude();
    end

    // watchdog against a hung run
    initial begin
        repeat (60000) @(posedge clock);
        fails++;
        conclude();
    end
endmodule

`default_nettype wire
